// [design/aiwc_pkg.sv]
// Package of register offsets, fields and codes for the input/reference/window block
package aiwc_pkg;
    localparam logic [7:0] SEL_OFFS      = 8'hBB;
    localparam logic [7:0] GT_LOW_OFFS   = 8'hC3;
    localparam logic [7:0] GT_HIGH_OFFS  = 8'hC4;
    localparam logic [7:0] LT_LOW_OFFS   = 8'hC5;
    localparam logic [7:0] LT_HIGH_OFFS  = 8'hC6;
    localparam logic [7:0] REFCTL_OFFS   = 8'hD1;
    localparam logic [7:0] STATUS_OFFS   = 8'hE8;
    localparam logic [7:0] SEL_RESET     = 8'h80;
    localparam logic [2:0] SEL_FIXED_TOP = 3'h4;
    localparam logic [7:0] GT_RESET      = 8'hFF;
    localparam logic [7:0] LT_RESET      = 8'h00;
    localparam logic [7:0] REFCTL_RESET  = 8'h00;
    localparam int         REF_GAIN_BIT  = 7;
    localparam int         REF_OVR_BIT   = 4;
    localparam int         REF_SEL_BIT   = 3;
    localparam int         REF_TEMP_BIT  = 2;
    localparam int         REF_BIAS_BIT  = 1;
    localparam int         REF_BUF_BIT   = 0;
    localparam int         STAT_FLAG_BIT = 0;
    localparam logic [4:0] CH_P3_0       = 5'h10;
    localparam logic [4:0] CH_P0_FIRST   = 5'h11;
    localparam logic [4:0] CH_P0_LAST    = 5'h14;
    localparam logic [4:0] CH_TEMP       = 5'h1E;
    localparam logic [4:0] CH_SUPPLY     = 5'h1F;
    localparam logic [13:0] TOFF_HIGH_ADDR = 14'h3FFB;
    localparam logic [13:0] TOFF_LOW_ADDR  = 14'h3FFA;
    typedef enum logic [1:0] {
        AIWC_REF_PIN    = 2'b00,
        AIWC_REF_SUPPLY = 2'b01,
        AIWC_REF_CORE   = 2'b10
    } aiwc_ref_t;
    typedef enum logic [2:0] {
        AIWC_SRC_PORT1   = 3'b000,
        AIWC_SRC_PORT2   = 3'b001,
        AIWC_SRC_PORT3   = 3'b010,
        AIWC_SRC_PORT0   = 3'b011,
        AIWC_SRC_TEMP    = 3'b100,
        AIWC_SRC_SUPPLY  = 3'b101,
        AIWC_SRC_RESERVE = 3'b110
    } aiwc_src_t;
endpackage

// [design/aiwc_top.sv]
// Input select, reference control and window compare logic around a 10-bit converter
`timescale 1ns/1ps
// Notes on behaviour
// [R1] Lower-limit low byte: 8-bit read/write, resets to zero.
// [R2] Inside mode: flag when greater-than limit < word < less-than limit.
// [R3] Outside mode: flag when word below lower or above upper boundary.
// [R4] Conversion words compare as 10-bit unsigned integers.
// [R5] Codes 0-7 pick port 1 pins, 8-15 pick port 2 pins.
// [R6] Code 16 picks port 3 pin 0; 17-20 pick port 0 pins 0,1,4,5.
// [R7] Code 30 temperature sensor, 31 supply, 21-29 reserved.
// [R8] Select register: code in bits 4:0, bits 7:5 read 100, reset 0x80.
// [R9] Temperature offset stored left-justified at two fixed code locations.
// [R10] Reference select 0 uses reference pin, 1 uses unregulated supply.
// [R11] Regulator override set uses core regulator regardless of select.
// [R12] Bias generator on when any user needs it or bias enable set.
// [R13] Buffer gain picks unity (1.2 V) or double (2.4 V) gain.
// [R14] Buffer enable drives on-chip reference onto the reference pin.
// [R15] Software sets converter port pins analog and crossbar-skipped.
// [R16] Inside or outside mode follows relative values of the two limits.
// [R17] Gain select is bit 7 of reference control; 0 double, 1 unity.
// [R18] Bits 4..0: override, ref select, sensor, bias, buffer; reset zero.
// [R19] Compare on each completed conversion; flag held until software clears.
// [R20] Limit word is high byte concatenated with low byte, result-justified.
module aiwc_top
    import aiwc_pkg::*;
#(
    parameter int          RES_BITS   = 10,
    parameter logic [7:0]  TOFF_HIGH  = 8'h00,
    parameter logic [7:0]  TOFF_LOW   = 8'h00
) (
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    input  wire logic [7:0]       sfr_addr_in,
    input  wire logic [7:0]       sfr_wdata_in,
    input  wire logic             sfr_wr_in,
    input  wire logic             sfr_rd_in,
    output logic      [7:0]       sfr_rdata_out,
    input  wire logic             conv_done_in,
    input  wire logic [15:0]      conv_word_in,
    input  wire logic             periph_bias_req_in,
    input  wire logic [13:0]      code_addr_in,
    output logic      [7:0]       code_data_out,
    output logic      [2:0]       input_source_out,
    output logic      [2:0]       input_pin_out,
    output logic      [1:0]       reference_source_out,
    output logic                  bias_on_out,
    output logic                  buffer_unity_gain_out,
    output logic                  buffer_drive_pin_out,
    output logic                  sensor_on_out,
    output logic                  window_compare_flag_out
);
    logic       rst_meta_q;
    logic       rst_sync_q;
    logic [4:0] chan_sel_q;
    logic [7:0] upper_low_q;
    logic [7:0] upper_high_q;
    logic [7:0] window_lower_limit_low_q;
    logic [7:0] window_lower_limit_high_q;
    logic [7:0] refctl_q;
    logic       flag_q;
    logic [2:0] src_q;
    logic [2:0] pin_q;
    logic [1:0] ref_q;
    logic       bias_q;
    logic [7:0] rdata_q;
    logic [7:0] code_q;

    // Reset released through two flops; asserts immediately
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    wire wr_sel   = sfr_wr_in && (sfr_addr_in == SEL_OFFS);
    wire wr_gtl   = sfr_wr_in && (sfr_addr_in == GT_LOW_OFFS);
    wire wr_gth   = sfr_wr_in && (sfr_addr_in == GT_HIGH_OFFS);
    wire wr_ltl   = sfr_wr_in && (sfr_addr_in == LT_LOW_OFFS);
    wire wr_lth   = sfr_wr_in && (sfr_addr_in == LT_HIGH_OFFS);
    wire wr_ref   = sfr_wr_in && (sfr_addr_in == REFCTL_OFFS);
    wire wr_stat  = sfr_wr_in && (sfr_addr_in == STATUS_OFFS);

    // Limit words share the result's justification; no realignment here
    wire [15:0] upper_word = {upper_high_q, upper_low_q};                           // R20
    wire [15:0] lower_word = {window_lower_limit_high_q, window_lower_limit_low_q}; // R20
    // Unsigned compare over the full result word, so either justification works
    wire [15:0] conv_word  = conv_word_in;                                          // R4
    wire        above_gt   = conv_word > upper_word;
    wire        below_lt   = conv_word < lower_word;
    wire        inside_mode = lower_word > upper_word;                              // R16
    wire        hit_inside  = above_gt && below_lt;                                 // R2
    wire        hit_outside = (conv_word < lower_word) || (conv_word > upper_word); // R3
    wire        window_hit  = inside_mode ? hit_inside : hit_outside;
    wire        flag_set    = conv_done_in && window_hit;                           // R19
    wire        flag_clr    = wr_stat && !sfr_wdata_in[STAT_FLAG_BIT];

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            chan_sel_q <= SEL_RESET[4:0];
        end else if (wr_sel) begin
            chan_sel_q <= sfr_wdata_in[4:0];  // R8
        end
    end

    // Limits reset to an empty outside window, so nothing flags until programmed
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            upper_low_q               <= GT_RESET;
            upper_high_q              <= GT_RESET;
            window_lower_limit_low_q  <= LT_RESET;     // R1
            window_lower_limit_high_q <= LT_RESET;
        end else begin
            if (wr_gtl) upper_low_q <= sfr_wdata_in;
            if (wr_gth) upper_high_q <= sfr_wdata_in;
            if (wr_ltl) window_lower_limit_low_q <= sfr_wdata_in; // R1
            if (wr_lth) window_lower_limit_high_q <= sfr_wdata_in;
        end
    end

    // Bits 6:5 unused and kept zero
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            refctl_q <= REFCTL_RESET; // R18
        end else if (wr_ref) begin
            refctl_q <= sfr_wdata_in & 8'h9F; // R17 R18
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else if (flag_set) begin
            flag_q <= 1'b1;  // R19
        end else if (flag_clr) begin
            flag_q <= 1'b0;
        end
    end

    // Channel decode
    logic [2:0] src_d;
    logic [2:0] pin_d;
    always_comb begin
        src_d = AIWC_SRC_RESERVE;
        pin_d = 3'h0;
        if (chan_sel_q[4:3] == 2'b00) begin
            src_d = AIWC_SRC_PORT1;          // R5
            pin_d = chan_sel_q[2:0];
        end else if (chan_sel_q[4:3] == 2'b01) begin
            src_d = AIWC_SRC_PORT2;          // R5
            pin_d = chan_sel_q[2:0];
        end else if (chan_sel_q == CH_P3_0) begin
            src_d = AIWC_SRC_PORT3;          // R6
        end else if (chan_sel_q >= CH_P0_FIRST && chan_sel_q <= CH_P0_LAST) begin
            src_d = AIWC_SRC_PORT0;          // R6
            case (chan_sel_q - CH_P0_FIRST)
                5'h0: pin_d = 3'h0;
                5'h1: pin_d = 3'h1;
                5'h2: pin_d = 3'h4;
                default: pin_d = 3'h5;
            endcase
        end else if (chan_sel_q == CH_TEMP) begin
            src_d = AIWC_SRC_TEMP;           // R7
        end else if (chan_sel_q == CH_SUPPLY) begin
            src_d = AIWC_SRC_SUPPLY;         // R7
        end
    end

    // Override beats the pin/supply choice
    wire [1:0] ref_d = refctl_q[REF_OVR_BIT] ? AIWC_REF_CORE :                   // R11
                       (refctl_q[REF_SEL_BIT] ? AIWC_REF_SUPPLY : AIWC_REF_PIN); // R10
    // Converter and sensor count as bias users here
    wire       bias_d = refctl_q[REF_BIAS_BIT] || periph_bias_req_in ||
                        refctl_q[REF_TEMP_BIT];                                   // R12

    wire [7:0] rd_mux =
        (sfr_addr_in == SEL_OFFS)     ? {SEL_FIXED_TOP, chan_sel_q} :            // R8
        (sfr_addr_in == GT_LOW_OFFS)  ? upper_low_q :
        (sfr_addr_in == GT_HIGH_OFFS) ? upper_high_q :
        (sfr_addr_in == LT_LOW_OFFS)  ? window_lower_limit_low_q :
        (sfr_addr_in == LT_HIGH_OFFS) ? window_lower_limit_high_q :
        (sfr_addr_in == REFCTL_OFFS)  ? refctl_q :
        (sfr_addr_in == STATUS_OFFS)  ? {7'h00, flag_q} : 8'h00;

    // Calibration offset left-justified in code bytes 0x3FFB and 0x3FFA
    wire [7:0] code_d = (code_addr_in == TOFF_HIGH_ADDR) ? TOFF_HIGH :           // R9
                        (code_addr_in == TOFF_LOW_ADDR)  ? {TOFF_LOW[7:6], 6'h00} : 8'h00;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            src_q  <= AIWC_SRC_PORT1;
            pin_q  <= 3'h0;
            ref_q  <= AIWC_REF_PIN;
            bias_q <= 1'b0;
        end else begin
            src_q  <= src_d;
            pin_q  <= pin_d;
            ref_q  <= ref_d;
            bias_q <= bias_d;
        end
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
            code_q  <= 8'h00;
        end else begin
            code_q <= code_d;
            if (sfr_rd_in) rdata_q <= rd_mux;
        end
    end

    assign sfr_rdata_out           = rdata_q;
    assign code_data_out           = code_q;
    assign input_source_out        = src_q;
    assign input_pin_out           = pin_q;
    assign reference_source_out    = ref_q;
    assign bias_on_out             = bias_q;
    assign buffer_unity_gain_out   = refctl_q[REF_GAIN_BIT]; // R13 R17
    assign buffer_drive_pin_out    = refctl_q[REF_BUF_BIT];  // R14
    assign sensor_on_out           = refctl_q[REF_TEMP_BIT];
    assign window_compare_flag_out = flag_q;
endmodule

// [testbench/aiwc_monitor.sv]
// Port checker for select, reference and window flag behaviour
`timescale 1ns/1ps
module aiwc_monitor
    import aiwc_pkg::*;
(
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       conv_done_in,
    input wire logic       periph_bias_req_in,
    input wire logic [2:0] input_source_out,
    input wire logic [1:0] reference_source_out,
    input wire logic       bias_on_out,
    input wire logic       buffer_drive_pin_out,
    input wire logic       window_compare_flag_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    wire flg    = window_compare_flag_out;
    wire clr    = sfr_wr_in && sfr_addr_in == STATUS_OFFS && !sfr_wdata_in[STAT_FLAG_BIT];
    wire rd_sel = sfr_rd_in && sfr_addr_in == SEL_OFFS;
    wire rd_ref = sfr_rd_in && sfr_addr_in == REFCTL_OFFS;
    sequence s_sel_wr; sfr_wr_in && sfr_addr_in == SEL_OFFS; endsequence
    sequence s_ref_wr; sfr_wr_in && sfr_addr_in == REFCTL_OFFS; endsequence
    property p_sel_top; rd_sel |=> sfr_rdata_out[7:5] == SEL_FIXED_TOP; endproperty
    a_sel_top: assert property (p_sel_top) else $error("select top bits wrong");
    property p_ref_unused; rd_ref |=> sfr_rdata_out[6:5] == 2'h0; endproperty
    a_ref_unused: assert property (p_ref_unused) else $error("unused bits read set");
    property p_temp_src; s_sel_wr ##0 sfr_wdata_in[4:0] == CH_TEMP
        |-> ##2 input_source_out == AIWC_SRC_TEMP; endproperty
    a_temp_src: assert property (p_temp_src) else $error("sensor not selected");
    property p_override; s_ref_wr ##0 sfr_wdata_in[REF_OVR_BIT]
        |-> ##2 reference_source_out == AIWC_REF_CORE; endproperty
    a_override: assert property (p_override) else $error("override ignored");
    property p_buf;
        s_ref_wr |=> buffer_drive_pin_out == $past(sfr_wdata_in[REF_BUF_BIT]);
    endproperty
    a_buf: assert property (p_buf) else $error("buffer drive wrong");
    property p_bias; periph_bias_req_in |=> bias_on_out; endproperty
    a_bias: assert property (p_bias) else $error("bias not forced on");
    property p_hold; flg && !clr |=> flg; endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_rise; $rose(flg) |-> $past(conv_done_in); endproperty
    a_rise: assert property (p_rise) else $error("flag without conversion");
endmodule
bind aiwc_top aiwc_monitor u_mon (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_wdata_in(sfr_wdata_in),
    .sfr_wr_in(sfr_wr_in),
    .sfr_rd_in(sfr_rd_in),
    .sfr_rdata_out(sfr_rdata_out),
    .conv_done_in(conv_done_in),
    .periph_bias_req_in(periph_bias_req_in),
    .input_source_out(input_source_out),
    .reference_source_out(reference_source_out),
    .bias_on_out(bias_on_out),
    .buffer_drive_pin_out(buffer_drive_pin_out),
    .window_compare_flag_out(window_compare_flag_out)
);

// [testbench/aiwc_analog_model.sv]
// Analog front end model: converts a requested level after a chosen delay
`timescale 1ns/1ps
module aiwc_analog_model (
    input  wire logic        clk_in,
    input  wire logic        start_in,
    input  wire logic [9:0]  level_in,
    input  wire logic [3:0]  delay_in,
    output logic             conv_done_out = 1'b0,
    output logic      [15:0] conv_word_out = 16'h0000
);
    logic [4:0] cnt_q = 5'h00;
    // Pins taken as analog inputs, skipped by the crossbar
    always @(posedge clk_in) begin
        conv_done_out <= 1'b0;
        conv_word_out <= ~conv_word_out; // Stale word never trusted
        if (start_in)
            cnt_q <= {1'b0, delay_in} + 5'h01;
        else if (cnt_q != 5'h00)
            cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01 && !start_in) begin
            conv_done_out <= 1'b1;
            conv_word_out <= {6'h00, level_in};
        end
    end
endmodule

// [testbench/tb_top.sv]
// Bench: registers, input select, reference controls, window flag
`timescale 1ns/1ps
module tb_top
    import aiwc_pkg::*;
;
    logic        clk_in = 1'b0, rstn_in = 1'b0, sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
    logic        periph_bias_req_in = 1'b0, start = 1'b0, conv_done_in, sensor_on_out;
    logic        bias_on_out, buffer_unity_gain_out, buffer_drive_pin_out, window_compare_flag_out;
    logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out, code_data_out, d;
    logic [15:0] conv_word_in, e;
    logic [13:0] code_addr_in = 14'h0000;
    logic [9:0]  level = 10'h000;
    logic [3:0]  dly = 4'h0;
    logic [2:0]  input_source_out, input_pin_out;
    logic [1:0]  reference_source_out;
    logic [31:0] seed = 32'hEF3965C3, r;
    int          miscompares = 0, checks_done = 0, cyc = 0;
    logic [7:0]  ra [7] = '{SEL_OFFS, GT_LOW_OFFS, GT_HIGH_OFFS, LT_LOW_OFFS, LT_HIGH_OFFS,
                            REFCTL_OFFS, 8'hA0};
    logic [7:0]  rv [7] = '{8'h80, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [9:0]  wl [8] = '{10'h000, 10'h03F, 10'h040, 10'h041,
                            10'h07F, 10'h080, 10'h081, 10'h3FF};
    logic [8:0]  cr [3] = '{9'h11B, 9'h08C, 9'h000};
    aiwc_top #(
        .TOFF_HIGH(8'hA5),
        .TOFF_LOW(8'h7F)
    ) uut (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .sfr_addr_in(sfr_addr_in),
        .sfr_wdata_in(sfr_wdata_in),
        .sfr_wr_in(sfr_wr_in),
        .sfr_rd_in(sfr_rd_in),
        .sfr_rdata_out(sfr_rdata_out),
        .conv_done_in(conv_done_in),
        .conv_word_in(conv_word_in),
        .periph_bias_req_in(periph_bias_req_in),
        .code_addr_in(code_addr_in),
        .code_data_out(code_data_out),
        .input_source_out(input_source_out),
        .input_pin_out(input_pin_out),
        .reference_source_out(reference_source_out),
        .bias_on_out(bias_on_out),
        .buffer_unity_gain_out(buffer_unity_gain_out),
        .buffer_drive_pin_out(buffer_drive_pin_out),
        .sensor_on_out(sensor_on_out),
        .window_compare_flag_out(window_compare_flag_out)
    );
    aiwc_analog_model u_afe (.clk_in(clk_in), .start_in(start), .level_in(level),
        .delay_in(dly), .conv_done_out(conv_done_in), .conv_word_out(conv_word_in));
    initial forever #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            summarize();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic expf(input logic [15:0] w, input logic [15:0] lt,
                                  input logic [15:0] gt);
        return (lt > gt) ? (w > gt && w < lt) : (w < lt || w > gt);
    endfunction
    function automatic logic [5:0] exps(input logic [4:0] c);
        logic [1:0] k;
        k = c[1:0] - 2'h1;
        if (c < 5'h10) return {2'h0, c[3], c[2:0]};
        if (c == 5'h10) return 6'h10;
        if (c <= 5'h14) return {3'h3, k[1], 1'b0, k[0]};
        return (c == CH_TEMP) ? 6'h20 : (c == CH_SUPPLY) ? 6'h28 : 6'h30;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_in) #1;
        sfr_addr_in = a;
        sfr_wdata_in = v;
        sfr_wr_in = 1'b1;
        @(posedge clk_in) #1;
        sfr_wr_in = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in) #1;
        sfr_addr_in = a;
        sfr_rd_in = 1'b1;
        @(posedge clk_in) #1;
        sfr_rd_in = 1'b0;
        v = sfr_rdata_out;
    endtask
    task automatic conv(input logic [9:0] w, input logic [15:0] lt, input logic [15:0] gt);
        logic f;
        wr_reg(STATUS_OFFS, 8'h00);
        r = rnd();
        start = 1'b1;
        level = w;
        dly = r[3:0];
        @(posedge clk_in) #1;
        start = 1'b0;
        repeat (20) @(posedge clk_in);
        #1 f = expf({6'h00, w}, lt, gt);
        chk({15'h0000, window_compare_flag_out}, {15'h0000, f});
        rd_reg(STATUS_OFFS, d);
        chk({8'h00, d}, {15'h0000, f});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        logic [15:0] lt, gt;
        repeat (8) @(posedge clk_in);
        #1 rstn_in = 1'b1;
        repeat (4) @(posedge clk_in);
        foreach (ra[i]) begin
            rd_reg(ra[i], d);
            chk({8'h00, d}, {8'h00, rv[i]});
        end
        r = rnd();
        wr_reg(8'hA0, r[7:0]);
        wr_reg(LT_LOW_OFFS, r[7:0]);
        rd_reg(LT_LOW_OFFS, d);
        chk({8'h00, d}, {8'h00, r[7:0]});
        $display("test registers done");
        for (int m = 0; m < 2; m++) begin
            lt = m ? 16'h0040 : 16'h0080;
            gt = m ? 16'h0080 : 16'h0040;
            wr_reg(LT_LOW_OFFS, lt[7:0]);
            wr_reg(LT_HIGH_OFFS, lt[15:8]);
            wr_reg(GT_LOW_OFFS, gt[7:0]);
            wr_reg(GT_HIGH_OFFS, gt[15:8]);
            foreach (wl[i]) conv(wl[i], lt, gt);
            for (int j = 0; j < 6; j++) conv(10'(rnd() >> 22), lt, gt);
        end
        $display("test window done");
        for (int c = 0; c < 32; c++) begin
            r = rnd();
            wr_reg(SEL_OFFS, {r[7:5], c[4:0]});
            rd_reg(SEL_OFFS, d);
            chk({8'h00, d}, {8'h00, 3'h4, c[4:0]});
            e = {10'h000, exps(c[4:0])};
            d = {2'h0, input_source_out, (input_source_out < 3'h4) ? input_pin_out : 3'h0};
            chk({8'h00, d}, e);
        end
        $display("test select done");
        for (int i = 0; i < 16; i++) begin
            r = rnd();
            if (i < 3) r[8:0] = cr[i];
            periph_bias_req_in = r[8];
            wr_reg(REFCTL_OFFS, r[7:0]);
            rd_reg(REFCTL_OFFS, d);
            chk({8'h00, d}, {8'h00, r[7:0] & 8'h9F});
            e = {10'h000, r[4] ? 2'h2 : {1'b0, r[3]}, r[7], r[0], r[2], r[1] | r[8] | r[2]};
            chk({10'h000, reference_source_out, buffer_unity_gain_out, buffer_drive_pin_out,
                 sensor_on_out, bias_on_out}, e);
        end
        code_addr_in = TOFF_HIGH_ADDR;
        @(posedge clk_in) #1 chk({8'h00, code_data_out}, 16'h00A5);
        code_addr_in = TOFF_LOW_ADDR;
        @(posedge clk_in) #1 chk({8'h00, code_data_out}, 16'h0040);
        $display("test reference done");
        summarize();
    end
endmodule
